//--- plt_link_tx.sv
// top of the display link transmitter: pixel capture, crossing, serializer
module plt_link_tx (
    // system clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // bit clock from the synthesizer, seven times the pixel rate
    input wire logic i_bit_clock,
    // parallel pixel side
    input wire logic i_pixel_clock_in,
    input wire logic i_capture_edge_select,
    input wire logic i_shutdown_clear_n,
    input wire logic [27:0] i_pixel_data,
    // serial lanes
    output logic [3:0] o_lane_data,
    output logic [3:0] o_lane_oe,
    output logic o_forwarded_link_clock,
    output logic o_forwarded_link_clock_oe
);
    // =================================================================
    // shutdown release into the system clock domain
    // =================================================================
    // the clear drops at once but lets go only after two system clocks,
    // so every capture flop sees its reset values on the first edges after
    // release and none can leave the clear out of step with the others
    logic wake_s1_q, wake_s2_q;
    logic wake_s1_d, wake_s2_d;

    always_comb begin
        wake_s1_d = 1'b1;
        wake_s2_d = wake_s1_q;
    end

    always_ff @(posedge i_clock or negedge i_shutdown_clear_n) begin
        if (!i_shutdown_clear_n) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end else begin
            wake_s1_q <= wake_s1_d;
            wake_s2_q <= wake_s2_d;
        end
    end

    // =================================================================
    // pixel capture in the system clock domain
    // =================================================================
    logic pclk_s1_q, pclk_s2_q, pclk_s3_q;
    logic pclk_s1_d, pclk_s2_d, pclk_s3_d;
    logic sel_s1_q, sel_s2_q;
    logic sel_s1_d, sel_s2_d;
    logic [27:0] data_s1_q, data_s2_q, hold_q;
    logic [27:0] data_s1_d, data_s2_d, hold_d;
    logic tog_q, tog_d;
    logic edge_hit;

    // pins pass two flops; data is delayed alongside the clock so the
    // word taken matches the level present at the pixel edge
    always_comb begin
        pclk_s1_d = i_pixel_clock_in;
        pclk_s2_d = pclk_s1_q;
        pclk_s3_d = pclk_s2_q;
        sel_s1_d = i_capture_edge_select;
        sel_s2_d = sel_s1_q;
        data_s1_d = i_pixel_data;
        data_s2_d = data_s1_q;
        // high select takes the rising edge, low the falling edge
        edge_hit = sel_s2_q ? (pclk_s2_q & ~pclk_s3_q)
                            : (~pclk_s2_q & pclk_s3_q);
        hold_d = hold_q;
        tog_d = tog_q;
        if (edge_hit) begin
            hold_d = data_s2_q;
            tog_d = ~tog_q;
        end
        if (!i_rst_n || !wake_s2_q) begin
            pclk_s1_d = 1'b0;
            pclk_s2_d = 1'b0;
            pclk_s3_d = 1'b0;
            sel_s1_d = 1'b0;
            sel_s2_d = 1'b0;
            data_s1_d = plt_pkg::WORD_RESET;
            data_s2_d = plt_pkg::WORD_RESET;
            hold_d = plt_pkg::WORD_RESET;
            tog_d = 1'b0;
        end
    end

    // shutdown clears the holding registers without waiting for a clock
    always_ff @(posedge i_clock or negedge i_shutdown_clear_n) begin
        if (!i_shutdown_clear_n) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
            data_s1_q <= plt_pkg::WORD_RESET;
            data_s2_q <= plt_pkg::WORD_RESET;
            hold_q <= plt_pkg::WORD_RESET;
            tog_q <= 1'b0;
        end else begin
            pclk_s1_q <= pclk_s1_d;
            pclk_s2_q <= pclk_s2_d;
            pclk_s3_q <= pclk_s3_d;
            sel_s1_q <= sel_s1_d;
            sel_s2_q <= sel_s2_d;
            data_s1_q <= data_s1_d;
            data_s2_q <= data_s2_d;
            hold_q <= hold_d;
            tog_q <= tog_d;
        end
    end

    // =================================================================
    // crossing into the bit clock domain
    // =================================================================
    // the held word stays put for a whole pixel period, far longer than
    // the toggle takes to cross, so it is read only after the toggle lands
    // limitation: a pixel period shorter than about four bit clocks plus
    // four system clocks can replace the held word while it is crossing;
    // the trade keeps the crossing to one toggle instead of a full fifo
    logic rst_s1_q, rst_s2_q, rst_s1_d, rst_s2_d;
    logic tog_s1_q, tog_s2_q, tog_s3_q;
    logic tog_s1_d, tog_s2_d, tog_s3_d;
    logic [27:0] word_q, word_d;
    logic run;

    assign run = rst_s2_q;

    always_comb begin
        rst_s1_d = i_rst_n;
        rst_s2_d = rst_s1_q;
        tog_s1_d = tog_q;
        tog_s2_d = tog_s1_q;
        tog_s3_d = tog_s2_q;
        word_d = word_q;
        if (tog_s2_q != tog_s3_q) begin
            word_d = hold_q;
        end
        if (!run) begin
            word_d = plt_pkg::WORD_RESET;
        end
    end

    always_ff @(posedge i_bit_clock or negedge i_shutdown_clear_n) begin
        if (!i_shutdown_clear_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
            word_q <= plt_pkg::WORD_RESET;
        end else begin
            rst_s1_q <= rst_s1_d;
            rst_s2_q <= rst_s2_d;
            tog_s1_q <= tog_s1_d;
            tog_s2_q <= tog_s2_d;
            tog_s3_q <= tog_s3_d;
            word_q <= word_d;
        end
    end

    // =================================================================
    // slice framing and forwarded clock
    // =================================================================
    logic [2:0] slot_q, slot_d;
    logic fclk_q, fclk_d;
    logic oe_q, oe_d;
    logic load;

    // one slice is seven bit clocks, so the framing clock runs at the
    // pixel rate; the slot freezes at zero while shutdown is low
    always_comb begin
        load = run && (slot_q == plt_pkg::SLOT_LAST);
        slot_d = load ? plt_pkg::SLOT_FIRST : slot_q + 3'h1;
        fclk_d = plt_pkg::LINK_CLOCK_PATTERN[3'h6 - slot_d];
        oe_d = 1'b1;
        if (!run) begin
            slot_d = plt_pkg::SLOT_FIRST;
            fclk_d = 1'b0;
            oe_d = 1'b0;
        end
    end

    always_ff @(posedge i_bit_clock or negedge i_shutdown_clear_n) begin
        if (!i_shutdown_clear_n) begin
            slot_q <= plt_pkg::SLOT_FIRST;
            fclk_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            slot_q <= slot_d;
            fclk_q <= fclk_d;
            oe_q <= oe_d;
        end
    end

    // =================================================================
    // four lanes, lane k carries word bits 7k+6 down to 7k
    // =================================================================
    // the shifter outputs gather in one vector first so the carrier
    // struct has a single driver
    plt_pkg::plt_lanes_t lanes;
    logic [3:0] lane_bits;

    for (genvar k = 0; k < plt_pkg::LANES; k++) begin : g_lane
        plt_lane_ser #(
            .WIDTH(plt_pkg::SLICE_BITS)
        ) u_ser (
            .i_bit_clock(i_bit_clock),
            .i_clear_n(i_shutdown_clear_n),
            .i_run(run),
            .i_load(load),
            .i_slice(word_q[k*plt_pkg::SLICE_BITS +: plt_pkg::SLICE_BITS]),
            .o_bit(lane_bits[k])
        );
    end

    assign lanes = '{data: lane_bits, clock: fclk_q};

    // drivers are off whenever the link is held in shutdown
    assign o_lane_data = lanes.data;
    assign o_lane_oe = {4{oe_q}};
    assign o_forwarded_link_clock = lanes.clock;
    assign o_forwarded_link_clock_oe = oe_q;
endmodule // plt_link_tx

//--- plt_lane_ser.sv
// package of link constants and the per-lane parallel-load shift register
// =====================================================================
// =====================================================================
package plt_pkg;
    // link shape
    localparam int unsigned DATA_WIDTH = 28;
    localparam int unsigned LANES = 4;
    localparam int unsigned SLICE_BITS = 7;
    // slot counter, slice boundary and reset value
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    // forwarded clock waveform, slot 0 first: high 2, low 3, high 2
    localparam logic [6:0] LINK_CLOCK_PATTERN = 7'h63;
    // supported pixel clock range, in MHz
    localparam int unsigned PIXEL_CLOCK_MIN_MHZ = 10;
    localparam int unsigned PIXEL_CLOCK_MAX_MHZ = 85;
    // reset values
    localparam logic [27:0] WORD_RESET = 28'h0000000;
    localparam logic [6:0] SLICE_RESET = 7'h00;

    // serial outputs that travel together
    typedef struct packed {
        logic [3:0] data;
        logic clock;
    } plt_lanes_t;
endpackage

// =====================================================================
// one lane: parallel load, serial out, msb first
// =====================================================================
module plt_lane_ser #(
    parameter int unsigned WIDTH = 7
) (
    // clock and clears
    input wire logic i_bit_clock,
    input wire logic i_clear_n,
    input wire logic i_run,
    // parallel side
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_slice,
    // serial side
    output logic o_bit
);
    logic [WIDTH-1:0] sh_q;
    logic [WIDTH-1:0] sh_d;

    // load at the slice boundary, otherwise shift one bit per bit clock
    always_comb begin
        sh_d = sh_q;
        if (!i_run) begin
            sh_d = '0;
        end else if (i_load) begin
            sh_d = i_slice;
        end else begin
            sh_d = {sh_q[WIDTH-2:0], 1'b0};
        end
    end

    // clear is asynchronous so shutdown wins even without a bit clock
    always_ff @(posedge i_bit_clock or negedge i_clear_n) begin
        if (!i_clear_n) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    assign o_bit = sh_q[WIDTH-1];
endmodule // plt_lane_ser

//--- plt_link_tx_sva.sv
// port assertions for the display link transmitter
module plt_link_tx_sva (
    // resets and link clock
    input wire logic i_rst_n,
    input wire logic i_bit_clock,
    input wire logic i_shutdown_clear_n,
    // serial lanes
    input wire logic [3:0] o_lane_data,
    input wire logic [3:0] o_lane_oe,
    input wire logic o_forwarded_link_clock,
    input wire logic o_forwarded_link_clock_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // link domain checks
    default clocking @(posedge i_bit_clock); endclocking
    default disable iff (!i_rst_n);
    property p_off;
        !i_shutdown_clear_n |-> o_lane_oe == 4'h0 && !o_forwarded_link_clock_oe;
    endproperty
    a_off: assert property (p_off) else $error("drivers on in shutdown");
    property p_clr;
        !i_shutdown_clear_n |-> o_lane_data == 4'h0 && !o_forwarded_link_clock;
    endproperty
    a_clr: assert property (p_clr) else $error("lanes not cleared");
    property p_oe;
        o_lane_oe == {4{o_forwarded_link_clock_oe}};
    endproperty
    a_oe: assert property (p_oe) else $error("lane enables differ");
    // clock runs are only judged once the drivers were already on
    property p_low;
        disable iff (!i_rst_n || !i_shutdown_clear_n)
        $fell(o_forwarded_link_clock) && $past(o_forwarded_link_clock_oe)
            |-> !o_forwarded_link_clock [*3] ##1 o_forwarded_link_clock;
    endproperty
    a_low: assert property (p_low) else $error("link clock low run");
    property p_high;
        disable iff (!i_rst_n || !i_shutdown_clear_n)
        $rose(o_forwarded_link_clock) && $past(o_forwarded_link_clock_oe)
            |-> o_forwarded_link_clock [*4] ##1 !o_forwarded_link_clock;
    endproperty
    a_high: assert property (p_high) else $error("link clock high run");
    property p_wake;
        $rose(i_shutdown_clear_n) |-> (o_lane_data == 4'h0) [*2];
    endproperty
    a_wake: assert property (p_wake) else $error("stale lane data");
    property p_run;
        $rose(i_shutdown_clear_n) |-> ##[1:10] o_forwarded_link_clock_oe;
    endproperty
    a_run: assert property (p_run) else $error("drivers never on");
    property p_hold;
        disable iff (!i_rst_n || !i_shutdown_clear_n)
        o_forwarded_link_clock_oe |=> o_forwarded_link_clock_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("drivers dropped");
endmodule // plt_link_tx_sva

//--- plt_panel_rx.sv
// behavioural panel receiver: rebuilds pixel words from the lanes
module plt_panel_rx (
    // link side
    input wire logic i_bit_clock,
    input wire plt_pkg::plt_lanes_t i_lanes,
    input wire logic i_driven,
    // recovered word
    output logic [27:0] o_word,
    output logic o_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] clk_q;
    logic [6:0] sh_q [4];
    logic [4:0] rx_l;
    // an undriven pair reads as the inverse of what the pins last showed
    assign rx_l = i_driven ? i_lanes : ~i_lanes;
    // every lane shifts in msb first; framing comes from the clock history
    always_ff @(posedge i_bit_clock) begin
        clk_q <= {clk_q[5:0], rx_l[0]};
        for (int k = 0; k < 4; k++)
            sh_q[k] <= {sh_q[k][5:0], rx_l[k+1]};
    end
    assign o_valid = i_driven && clk_q == plt_pkg::LINK_CLOCK_PATTERN;
    assign o_word = {sh_q[3], sh_q[2], sh_q[1], sh_q[0]};
endmodule // plt_panel_rx

//--- plt_link_tx_bench.sv
// self-checking bench for the display link transmitter
module plt_link_tx_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1, i_rst_n = 0, i_bit_clock = 0, i_pixel_clock_in = 0;
    logic i_capture_edge_select = 1, i_shutdown_clear_n = 0, rx_valid, chk = 0;
    logic [27:0] i_pixel_data = 28'h0, rx_word, nw;
    logic [3:0] o_lane_data, o_lane_oe;
    logic o_forwarded_link_clock, o_forwarded_link_clock_oe;
    logic [5:0][27:0] good = '0;
    logic [31:0] w;
    int failures = 0, compares = 0, seed = 46, cyc = 0, gap = 0, words = 0, n, base;
    plt_link_tx u_plt_link_tx (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_bit_clock(i_bit_clock), .i_pixel_clock_in(i_pixel_clock_in),
        .i_capture_edge_select(i_capture_edge_select),
        .i_shutdown_clear_n(i_shutdown_clear_n), .i_pixel_data(i_pixel_data),
        .o_lane_data(o_lane_data), .o_lane_oe(o_lane_oe),
        .o_forwarded_link_clock(o_forwarded_link_clock),
        .o_forwarded_link_clock_oe(o_forwarded_link_clock_oe));
    plt_panel_rx u_plt_panel_rx (.i_bit_clock(i_bit_clock),
        .i_lanes({o_lane_data, o_forwarded_link_clock}),
        .i_driven(&{o_lane_oe, o_forwarded_link_clock_oe}),
        .o_word(rx_word), .o_valid(rx_valid));
    // =====================================================================
    // clocks: bit clock offset by 5 ns so its edges never meet the system clock
    always #4 i_clock = ~i_clock;
    always #16 i_bit_clock <= #5 ~i_bit_clock;
    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    function automatic bit seen(input logic [27:0] v);
        seen = 0;
        for (int k = 0; k < 6; k++)
            seen |= good[k] === v;
    endfunction
    // =====================================================================
    // pixel source: 240 ns pixels; a good word sits only around the chosen
    // edge and its inverse around the other, so a wrong edge is caught
    always @(negedge i_clock) begin
        cyc <= (cyc == 29) ? 0 : cyc + 1;
        if (cyc == 0 || cyc == 15)
            i_pixel_clock_in <= ~i_pixel_clock_in;
        if (cyc == (i_capture_edge_select ? 23 : 8)) begin
            w = $random(seed);
            nw = (w[31:30] == 2'h3) ? 28'hfffffff : w[27:0];
            // some words are eighteen-bit colour with the unused inputs low
            if (w[31:30] == 2'h2)
                nw = w[27:0] & 28'h77cf3df;
            i_pixel_data <= nw;
            good <= {good[4:0], nw};
        end
        if (cyc == (i_capture_edge_select ? 7 : 22))
            i_pixel_data <= ~good[0];
    end
    // receiver monitor: one slice every seven bit clocks, each a recent word
    always @(negedge i_bit_clock) begin
        gap <= gap + 1;
        if (rx_valid === 1'b1 && chk) begin
            check(gap == 7, "slice length");
            check(seen(rx_word), "word mismatch");
            words <= words + 1;
        end
        if (rx_valid === 1'b1)
            gap <= 1;
    end
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // =====================================================================
    // each edge select: shut down (mid-run for the second), release, then stream words
    initial begin
        repeat (5) @(negedge i_clock);
        i_rst_n <= 1;
        for (int s = 1; s >= 0; s--) begin
            i_shutdown_clear_n <= 0;
            chk <= 0;
            #1;
            check(o_lane_oe === 4'h0 && o_forwarded_link_clock_oe === 1'b0, "oe");
            check(o_lane_data === 4'h0, "lanes not cleared");
            @(negedge i_clock);
            i_capture_edge_select <= s[0];
            repeat (20) @(negedge i_clock);
            i_shutdown_clear_n <= 1;
            for (n = 0; n < 200 && rx_valid !== 1'b1; n++)
                @(negedge i_clock);
            if (n == 200) begin
                failures++;
                $display("CHECK FAILED %0t link never woke", $time);
                break;
            end
            check(&{o_lane_oe, o_forwarded_link_clock_oe} === 1'b1, "drivers off");
            repeat (120) @(negedge i_clock);
            base = words;
            chk <= 1;
            repeat (300) @(negedge i_clock);
            check(words - base > 8, "too few words");
            $display("edge select %0d done", s);
        end
        conclude();
    end
endmodule // plt_link_tx_bench
bind plt_link_tx plt_link_tx_sva u_plt_link_tx_sva (.i_rst_n(i_rst_n),
    .i_bit_clock(i_bit_clock), .i_shutdown_clear_n(i_shutdown_clear_n),
    .o_lane_data(o_lane_data), .o_lane_oe(o_lane_oe),
    .o_forwarded_link_clock(o_forwarded_link_clock),
    .o_forwarded_link_clock_oe(o_forwarded_link_clock_oe));
